// ===== test_mode_config_readout_tb_top.sv
`timescale 1ns/1ps
module test_mode_config_readout_tb_top import tmr_pkg::*; ();
	logic       clk_sys, resetn, entry_threshold, exit_threshold;
	logic       cfg_wr, ee_req, ee_ack, reload_req, reload_done;
	logic       alarm_out, alarm_oe_n, test_active;
	logic [6:0] cfg_addr, ee_slave_id, ee_addr, reload_last;
	logic [7:0] cfg_wdata, cfg_rdata, ee_rdata, sid;
	logic [7:0] ram_img [0:127];
	logic [7:0] exp_q [$];
	logic [31:0] seed;
	int         n_fail, comparisons, half, got_n;

	tmr_readout i_tmr_readout (.clk_sys(clk_sys), .resetn(resetn),
		.clk_en(1'b1), .entry_threshold(entry_threshold),
		.exit_threshold(exit_threshold), .cfg_wr(cfg_wr),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.ee_req(ee_req), .ee_slave_id(ee_slave_id), .ee_addr(ee_addr),
		.ee_ack(ee_ack), .ee_rdata(ee_rdata), .reload_req(reload_req),
		.reload_last(reload_last), .reload_done(reload_done),
		.alarm_out(alarm_out), .alarm_oe_n(alarm_oe_n),
		.test_active(test_active));
	tmr_ee_model i_tmr_ee_model (.clk_sys(clk_sys), .resetn(resetn),
		.ee_req(ee_req), .ee_addr(ee_addr), .ee_ack(ee_ack),
		.ee_rdata(ee_rdata), .reload_req(reload_req),
		.reload_done(reload_done));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		xs = t ^ (t << 5);
	endfunction
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		if (n_fail == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		cfg_wr <= 1'b1;
		cfg_addr <= a;
		cfg_wdata <= d;
		@(posedge clk_sys);
		cfg_wr <= 1'b0;
	endtask
	task automatic pulse(input logic ent);
		@(posedge clk_sys);
		if (ent) entry_threshold <= 1'b1;
		else exit_threshold <= 1'b1;
		@(posedge clk_sys);
		entry_threshold <= 1'b0;
		exit_threshold <= 1'b0;
	endtask
	task automatic wait_bytes(input int n);
		int k;
		for (k = 0; k < 20000 && got_n < n; k++) @(posedge clk_sys);
		if (got_n < n) begin
			n_fail++;
			close_out();
		end
	endtask
	task automatic wait_rl(input logic v);
		int k;
		for (k = 0; k < 200 && reload_req !== v; k++) @(negedge clk_sys);
		if (reload_req !== v) begin
			n_fail++;
			close_out();
		end
	endtask
	// Enters test mode, checks n bytes, then leaves mid-stream or idle.
	task automatic run(input logic [7:0] tf, input logic [7:0] src,
		input logic [6:0] first, input int n);
		int i;
		wr(TMR_ADDR_TEST_FUNC, tf);
		wr(TMR_ADDR_READ_SRC, src);
		half = src[0] ? TMR_FAST_CYC : TMR_SLOW_CYC;
		for (i = 0; i < n; i++)
			exp_q.push_back((tf[6] && !tf[7] && src[7]) ? ram_img[first + i]
				: {1'b0, 7'(first + i)} ^ 8'hA5);
		got_n = 0;
		pulse(1'b1);
		wait_bytes(n);
		repeat (half * 4) @(posedge clk_sys);
		cmp(8'(got_n), 8'(n));
		pulse(1'b0);
		@(negedge clk_sys);
		cmp({7'h00, reload_req}, 8'h01);
		cmp({1'b0, reload_last}, 8'h21);
		cmp({1'b0, ee_slave_id}, {1'b0, sid[6:0]});
		repeat (2) @(negedge clk_sys);
		cmp({7'h00, alarm_oe_n}, 8'h01);
		cmp({7'h00, test_active}, 8'h00);
		wait_rl(1'b0);
		exp_q.delete();
		repeat (400) @(posedge clk_sys);
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// Decodes one frame per start edge; sink on reads as 1.
	initial begin : watch
		int i;
		logic [17:0] s;
		logic [7:0] b, e;
		forever begin
			@(negedge alarm_oe_n);
			repeat (half / 2) @(negedge clk_sys);
			for (i = 17; i >= 0; i--) begin
				s[i] = ~alarm_oe_n;
				repeat (half) @(negedge clk_sys);
			end
			for (i = 0; i < 8; i++) begin
				b[7 - i] = s[15 - 2 * i];
				e[7 - i] = s[14 - 2 * i];
			end
			// Frames cut short by an exit carry no valid byte.
			if (test_active === 1'b1 && exp_q.size() > 0) begin
				cmp({6'h00, s[17:16]}, 8'h02);
				cmp(b ^ e, 8'hFF);
				cmp(b, exp_q.pop_front());
				cmp({7'h00, alarm_oe_n}, 8'h01);
				got_n++;
			end
		end
	end

	initial begin : main
		int i;
		resetn = 1'b0;
		entry_threshold = 1'b0;
		exit_threshold = 1'b0;
		cfg_wr = 1'b0;
		cfg_addr = 7'h00;
		cfg_wdata = 8'h00;
		n_fail = 0;
		comparisons = 0;
		half = TMR_SLOW_CYC;
		seed = 32'h6AC7;
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		for (i = 'h3B; i <= 'h43; i++) begin
			seed = xs(seed);
			ram_img[i] = seed[7:0];
			wr(7'(i), seed[7:0]);
		end
		seed = xs(seed);
		sid = seed[7:0] | 8'h80;
		wr(TMR_ADDR_SLAVE_ID, sid);
		repeat (2) @(negedge clk_sys);
		cmp(cfg_rdata, sid);
		for (i = 0; i < 2; i++) begin
			wr(TMR_ADDR_TEST_FUNC, i ? 8'h80 : 8'h00);
			pulse(1'b1);
			repeat (4) @(negedge clk_sys);
			cmp({7'h00, test_active}, 8'h00);
			pulse(1'b0);
			repeat (4) @(negedge clk_sys);
			cmp({7'h00, reload_req}, 8'h00);
		end
		wr(TMR_ADDR_TEST_FUNC, 8'h40);
		pulse(1'b1);
		@(negedge clk_sys);
		cmp({7'h00, test_active}, 8'h01);
		wr(TMR_ADDR_TEST_FUNC, 8'h00);
		pulse(1'b0);
		repeat (4) @(negedge clk_sys);
		cmp({7'h00, reload_req}, 8'h00);
		cmp({7'h00, test_active}, 8'h00);
		run(8'h40, 8'h80, TMR_RAM_FIRST, 9);
		run(8'h40, 8'h01, TMR_EE_PART_FIRST, 2);
		run(8'hC0, 8'h81, TMR_EE_FULL_FIRST, 3);
		cmp({7'h00, alarm_out}, 8'h00);
		close_out();
	end
endmodule // test_mode_config_readout_tb_top

// ===== tmr_ee_model.sv
`timescale 1ns/1ps
module tmr_ee_model (
	// Clock and reset.
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	// Byte channel.
	input  wire logic       ee_req,
	input  wire logic [6:0] ee_addr,
	output logic            ee_ack,
	output logic [7:0]      ee_rdata,
	// Reload handshake.
	input  wire logic       reload_req,
	output logic            reload_done
);
	logic [2:0] age_q;
	// A free running count gives a latency that varies from byte to byte.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			age_q <= 3'h0;
			ee_ack <= 1'b0;
			ee_rdata <= 8'h00;
			reload_done <= 1'b0;
		end else begin
			age_q <= age_q + 3'h1;
			ee_ack <= ee_req && !ee_ack && age_q[1:0] == 2'h0;
			// Outside an answer the data bus toggles, so stale bytes show.
			if (ee_req && !ee_ack && age_q[1:0] == 2'h0)
				ee_rdata <= {1'b0, ee_addr} ^ 8'hA5;
			else
				ee_rdata <= ~ee_rdata;
			reload_done <= reload_req && !reload_done && age_q == 3'h5;
		end
	end
endmodule // tmr_ee_model

// ===== tmr_pkg.sv
package tmr_pkg;
	// Register map (indices of the configuration RAM).
	localparam logic [6:0] TMR_ADDR_SLAVE_ID   = 7'h00;
	localparam logic [6:0] TMR_ADDR_TEST_FUNC  = 7'h15;
	localparam logic [6:0] TMR_ADDR_READ_SRC   = 7'h18;
	// Field positions.
	localparam int TMR_SLAVE_ID_MSB  = 6;
	localparam int TMR_TEST_FUNC_MSB = 7;
	localparam int TMR_TEST_FUNC_LSB = 6;
	localparam int TMR_READ_SRC_BIT  = 7;
	localparam int TMR_FAST_RATE_BIT = 0;
	// Test function codes.
	localparam logic [1:0] TMR_TF_OFF      = 2'b00;
	localparam logic [1:0] TMR_TF_PARTIAL  = 2'b01;
	localparam logic [1:0] TMR_TF_FULL     = 2'b11;
	// Address ranges sent or reloaded.
	localparam logic [6:0] TMR_EE_PART_FIRST  = 7'h1B;
	localparam logic [6:0] TMR_EE_LAST        = 7'h7F;
	localparam logic [6:0] TMR_RAM_FIRST      = 7'h3B;
	localparam logic [6:0] TMR_RAM_LAST       = 7'h43;
	localparam logic [6:0] TMR_EE_FULL_FIRST  = 7'h00;
	localparam logic [6:0] TMR_RELOAD_LAST    = 7'h21;
	// Frame layout: start bit, eight data bits, pause bits.
	localparam int TMR_DATA_BITS  = 8;
	localparam int TMR_PAUSE_BITS = 1;
	// Output clock half-bit times in picoseconds and clock period.
	localparam int TMR_CLK_PS      = 40000;
	localparam int TMR_FAST_PS     = 780000;
	localparam int TMR_SLOW_PS     = 3125000;
	localparam int TMR_FAST_CYC    = TMR_FAST_PS / TMR_CLK_PS;
	localparam int TMR_SLOW_CYC    = TMR_SLOW_PS / TMR_CLK_PS;
	localparam int TMR_CNT_W       = 7;
	// Reset value of the configuration RAM.
	localparam logic [7:0] TMR_RAM_RESET = 8'h00;
	// Transmitter states.
	typedef enum logic [3:0] {
		TMR_IDLE  = 4'b0001,
		TMR_FETCH = 4'b0010,
		TMR_SEND  = 4'b0100,
		TMR_WAIT  = 4'b1000
	} tmr_state_e;
	// Last count of a half-bit period, one less than its length in system clock cycles.
	function automatic logic [TMR_CNT_W-1:0] tmr_half_len(input logic fast);
		tmr_half_len = fast ? TMR_CNT_W'(TMR_FAST_CYC - 1)
			: TMR_CNT_W'(TMR_SLOW_CYC - 1);
	endfunction
endpackage

// ===== tmr_readout.sv
`timescale 1ns/1ps
module tmr_readout import tmr_pkg::*; (
	// Clock and reset.
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	input  wire logic       clk_en,
	// Alarm pin threshold detectors.
	input  wire logic       entry_threshold,
	input  wire logic       exit_threshold,
	// Configuration RAM write port.
	input  wire logic       cfg_wr,
	input  wire logic [6:0] cfg_addr,
	input  wire logic [7:0] cfg_wdata,
	// Configuration RAM read port.
	output logic [7:0]      cfg_rdata,
	// External EEPROM read channel.
	output logic            ee_req,
	output logic [6:0]      ee_slave_id,
	output logic [6:0]      ee_addr,
	input  wire logic       ee_ack,
	input  wire logic [7:0] ee_rdata,
	// Reload after test mode.
	output logic            reload_req,
	output logic [6:0]      reload_last,
	input  wire logic       reload_done,
	// Alarm pin low-side sink, output enable low while sinking.
	output logic            alarm_out,
	output logic            alarm_oe_n,
	// Status.
	output logic            test_active
);
	logic [7:0]  ram_q [0:127];
	logic [6:0]  ptr_q;
	logic [6:0]  last_q;
	logic        from_ee_q;
	logic [7:0]  byte_q;
	logic        load_q;
	tmr_state_e  state_q;
	logic        in_test_q;
	logic        tick;
	logic        busy;
	logic        sink_on;
	logic [1:0]  tfunc;
	logic        src_ram;
	logic        leave;
	logic        enter;

	assign tfunc   =
		ram_q[TMR_ADDR_TEST_FUNC][TMR_TEST_FUNC_MSB:TMR_TEST_FUNC_LSB];
	assign src_ram = ram_q[TMR_ADDR_READ_SRC][TMR_READ_SRC_BIT];
	assign enter   = !in_test_q && entry_threshold && tfunc[0];
	assign leave   = in_test_q && exit_threshold;

	// Configuration RAM; test equipment reads back what software stored.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < 128; i++) begin
				ram_q[i] <= TMR_RAM_RESET;
			end
			cfg_rdata <= '0;
		end else if (clk_en) begin
			if (cfg_wr) begin
				ram_q[cfg_addr] <= cfg_wdata;
			end
			cfg_rdata <= ram_q[cfg_addr];
		end
	end

	// Test mode entry and exit.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			in_test_q   <= 1'b0;
			test_active <= 1'b0;
		end else if (clk_en) begin
			if (enter) begin
				in_test_q <= 1'b1;
			end else if (leave) begin
				in_test_q <= 1'b0;
			end
			test_active <= enter || (in_test_q && !leave);
		end
	end

	// Reload request on exit with a nonzero function.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			reload_req  <= 1'b0;
			reload_last <= '0;
			ee_slave_id <= '0;
		end else if (clk_en) begin
			ee_slave_id <= ram_q[TMR_ADDR_SLAVE_ID][TMR_SLAVE_ID_MSB:0];
			if (leave && tfunc != TMR_TF_OFF) begin
				reload_req  <= 1'b1;
				reload_last <= TMR_RELOAD_LAST;
			end else if (reload_done) begin
				reload_req <= 1'b0;
			end
		end
	end

	// Byte sequencer.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_q   <= TMR_IDLE;
			ptr_q     <= '0;
			last_q    <= '0;
			from_ee_q <= 1'b0;
			byte_q    <= '0;
			load_q    <= 1'b0;
			ee_req    <= 1'b0;
			ee_addr   <= '0;
		end else if (clk_en) begin
			load_q <= 1'b0;
			if (leave) begin
				state_q <= TMR_IDLE;
				ee_req  <= 1'b0;
			end else begin
				case (state_q)
					TMR_IDLE: begin
						if (enter) begin
							if (tfunc == TMR_TF_FULL) begin
								ptr_q     <= TMR_EE_FULL_FIRST;
								last_q    <= TMR_EE_LAST;
								from_ee_q <= 1'b1;
							end else if (src_ram) begin
								ptr_q     <= TMR_RAM_FIRST;
								last_q    <= TMR_RAM_LAST;
								from_ee_q <= 1'b0;
							end else begin
								ptr_q     <= TMR_EE_PART_FIRST;
								last_q    <= TMR_EE_LAST;
								from_ee_q <= 1'b1;
							end
							state_q <= TMR_FETCH;
						end
					end
					TMR_FETCH: begin
						if (!from_ee_q) begin
							byte_q  <= ram_q[ptr_q];
							load_q  <= 1'b1;
							state_q <= TMR_SEND;
						end else if (ee_req && ee_ack) begin
							ee_req  <= 1'b0;
							byte_q  <= ee_rdata;
							load_q  <= 1'b1;
							state_q <= TMR_SEND;
						end else begin
							ee_req  <= 1'b1;
							ee_addr <= ptr_q;
						end
					end
					TMR_SEND: begin
						if (busy) begin
							state_q <= TMR_WAIT;
						end
					end
					TMR_WAIT: begin
						if (!busy) begin
							if (ptr_q == last_q) begin
								state_q <= TMR_IDLE;
							end else begin
								ptr_q   <= ptr_q + 1'b1;
								state_q <= TMR_FETCH;
							end
						end
					end
					default: state_q <= TMR_IDLE;
				endcase
			end
		end
	end

	tmr_timebase u_timebase (
		.clk_sys          (clk_sys),
		.resetn           (resetn),
		.clk_en           (clk_en),
		.run              (busy),
		.fast_rate_select (ram_q[TMR_ADDR_READ_SRC][TMR_FAST_RATE_BIT]),
		.tick             (tick)
	);

	tmr_shifter u_shifter (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.clk_en  (clk_en),
		.load    (load_q),
		.data    (byte_q),
		.abort   (leave),
		.tick    (tick),
		.busy    (busy),
		.sink_on (sink_on)
	);

	// Open-drain sink: line pulled low only while sinking.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			alarm_out  <= 1'b0;
			alarm_oe_n <= 1'b1;
		end else if (clk_en) begin
			alarm_out  <= 1'b0;
			alarm_oe_n <= !(sink_on && in_test_q);
		end
	end

	// Entry, exit and reload.
	a_no_entry: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		clk_en && !in_test_q && entry_threshold && !tfunc[0]
		|=> !in_test_q)
		else $error("test mode entered while disabled");
	a_test_flag: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		clk_en && enter |=> in_test_q && test_active)
		else $error("test mode not entered");
	a_exit_abort: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		clk_en && leave |=> state_q == TMR_IDLE && !busy)
		else $error("transmission not aborted on exit");
	a_exit_quiet: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		clk_en && leave |=> ##1 alarm_oe_n)
		else $error("line still sinking after exit");
	a_reload_req: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		clk_en && leave && tfunc != TMR_TF_OFF
		|=> reload_req && reload_last == TMR_RELOAD_LAST)
		else $error("no reload on exit");
	a_reload_hold: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		clk_en && reload_req && !reload_done |=> reload_req)
		else $error("reload request dropped early");
	a_no_reload: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		clk_en && leave && tfunc == TMR_TF_OFF && !reload_req
		|=> !reload_req)
		else $error("reload with function zero");
	a_slave_id: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		clk_en |=> ee_slave_id ==
		$past(ram_q[TMR_ADDR_SLAVE_ID][TMR_SLAVE_ID_MSB:0]))
		else $error("slave id mismatch");

	// Ranges and byte sources.
	a_ram_range: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		clk_en && enter && tfunc == TMR_TF_PARTIAL && src_ram
		|=> ptr_q == TMR_RAM_FIRST && last_q == TMR_RAM_LAST)
		else $error("wrong RAM range");
	a_part_range: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		clk_en && enter && tfunc == TMR_TF_PARTIAL && !src_ram
		|=> from_ee_q && ptr_q == TMR_EE_PART_FIRST
		&& last_q == TMR_EE_LAST)
		else $error("wrong partial EEPROM range");
	a_full_range: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		clk_en && enter && tfunc == TMR_TF_FULL
		|=> from_ee_q && ptr_q == TMR_EE_FULL_FIRST)
		else $error("wrong full range");
	a_range_bound: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		state_q != TMR_IDLE |-> ptr_q <= last_q)
		else $error("address beyond range");
	a_ascend: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		clk_en && state_q == TMR_WAIT && !busy && ptr_q != last_q && !leave
		|=> ptr_q == $past(ptr_q) + 7'h01)
		else $error("address not ascending");
	a_ram_byte: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		clk_en && state_q == TMR_FETCH && !from_ee_q && !leave
		|=> load_q && byte_q == $past(ram_q[ptr_q]))
		else $error("RAM byte not loaded");
	a_ee_hold: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		clk_en && ee_req && !ee_ack && !leave
		|=> ee_req && $stable(ee_addr))
		else $error("EEPROM request not held");
	a_ee_take: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		clk_en && ee_req && ee_ack && !leave
		|=> !ee_req && load_q && byte_q == $past(ee_rdata))
		else $error("EEPROM byte not taken");

	// Pin drive.
	a_oe_idle: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		clk_en && !in_test_q |=> alarm_oe_n)
		else $error("line sinks outside test mode");
	a_out_low: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		alarm_out == 1'b0)
		else $error("pin level not low");

	c_enter: cover property (@(posedge clk_sys) enter);
	c_ram_send: cover property (@(posedge clk_sys)
		state_q == TMR_WAIT && !from_ee_q && !busy);
	c_reload: cover property (@(posedge clk_sys) $rose(reload_req));
	c_abort: cover property (@(posedge clk_sys) leave && busy);
endmodule // tmr_readout

// ===== tmr_shifter.sv
`timescale 1ns/1ps
module tmr_shifter import tmr_pkg::*; (
	// Clock and reset.
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	input  wire logic       clk_en,
	// Control.
	input  wire logic       load,
	input  wire logic [7:0] data,
	input  wire logic       abort,
	input  wire logic       tick,
	// Status and line.
	output logic            busy,
	output logic            sink_on
);
	localparam int NB = 1 + TMR_DATA_BITS + TMR_PAUSE_BITS;
	logic [NB-1:0] sh_q;
	logic [4:0]    half_q;
	logic          second_q;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sh_q     <= '0;
			half_q   <= '0;
			second_q <= 1'b0;
			busy     <= 1'b0;
			sink_on  <= 1'b0;
		end else if (clk_en) begin
			if (abort) begin
				busy    <= 1'b0;
				sink_on <= 1'b0;
			end else if (load && !busy) begin
				sh_q     <= {1'b1, data, 1'b0};
				half_q   <= 5'(2 * NB);
				second_q <= 1'b0;
				busy     <= 1'b1;
			end else if (busy && tick) begin
				if (half_q <= 5'd2 * 5'(TMR_PAUSE_BITS)) begin
					sink_on <= 1'b0;
				end else begin
					// One bit: on then off; zero bit: off then on.
					sink_on <= second_q ? ~sh_q[NB-1] : sh_q[NB-1];
				end
				if (second_q) begin
					sh_q <= {sh_q[NB-2:0], 1'b0};
				end
				second_q <= ~second_q;
				half_q   <= half_q - 1'b1;
				if (half_q == 5'd1) begin
					busy <= 1'b0;
				end
			end
		end
	end

	a_pause_off: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		busy && half_q <= 5'd1 |-> !sink_on)
		else $error("line sinks during pause");
	a_idle_off: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		!busy |-> !sink_on)
		else $error("line sinks outside a frame");
	c_frame: cover property (@(posedge clk_sys) disable iff (!resetn)
		$fell(busy));
endmodule // tmr_shifter

// ===== tmr_timebase.sv
`timescale 1ns/1ps
module tmr_timebase import tmr_pkg::*; (
	// Clock and reset.
	input  wire logic clk_sys,
	input  wire logic resetn,
	input  wire logic clk_en,
	// Control.
	input  wire logic run,
	input  wire logic fast_rate_select,
	// Half-bit tick.
	output logic      tick
);
	logic [TMR_CNT_W-1:0] cnt_q;

	// Restarting on run keeps the first half-bit a full period long.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end else if (clk_en) begin
			if (!run || cnt_q == tmr_half_len(fast_rate_select)) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
			tick <= run && cnt_q == tmr_half_len(fast_rate_select);
		end
	end
endmodule // tmr_timebase
